// ### rtl/two_wire_defines.vh
// Register map, field positions, status codes and reset values of the two-wire unit
`ifndef TWO_WIRE_DEFINES_VH
`define TWO_WIRE_DEFINES_VH

// ==========================================================
// Register byte addresses
`define A_STAT        5'h00
`define A_DATA        5'h04
`define A_ADDR        5'h08
`define A_CTRL        5'h0c
`define A_RATE        5'h10

// ==========================================================
// Control register fields
`define C_FLAG        7
`define C_ACKEN       6
`define C_STA         5
`define C_STO         4
`define C_WCOL        3
`define C_EN          2
`define C_IE          0

// ==========================================================
// Reset values and constants
`define DATA_RST      8'hff
`define GC_ADDR       7'h00
`define CNT_ACK       4'h8
`define CNT_LAST      4'h7
`define CNT_SYNC      4'hf
`define HALF_ZERO     16'h0000

// ==========================================================
// Status codes
`define CODE_NONE     5'h1f
`define CODE_START    5'h01
`define CODE_RSTART   5'h02
`define CODE_MT_SLA_A 5'h03
`define CODE_MT_SLA_N 5'h04
`define CODE_MT_DAT_A 5'h05
`define CODE_MT_DAT_N 5'h06
`define CODE_ARB_LOST 5'h07
`define CODE_MR_SLA_A 5'h08
`define CODE_MR_SLA_N 5'h09
`define CODE_MR_DAT_A 5'h0a
`define CODE_MR_DAT_N 5'h0b
`define CODE_SR_SLA   5'h0c
`define CODE_SR_GC    5'h0d
`define CODE_SR_DAT   5'h0e
`define CODE_SR_STOP  5'h0f
`define CODE_ST_SLA   5'h10
`define CODE_ST_DAT_A 5'h11
`define CODE_ST_DAT_N 5'h12

`endif

// ### rtl/two_wire_unit.v
// Two-wire serial unit: status, shift data and own-address registers with byte engine
//
// Behaviour
// - Status code sits in bits 7..3 of the bus status register.
// - Status read returns status code and prescaler select in one byte.
// - Status bit 2 always reads zero.
// - Prescaler bits read/write; select factor 1, 4, 16 or 64.
// - Data register holds next byte to send or last byte received.
// - Data register writable only while the job-done flag is set.
// - Data register not shifted by the bus while the job-done flag is set.
// - Bus data shifts in while a byte shifts out.
// - Data register content after sleep wake-up need not be defined.
// - Bus data keeps shifting into the data register when arbitration is lost.
// - Acknowledge generated and sampled internally; the sampled value shows to software only through the status code.
// - Upper seven own-address bits hold the slave address answered.
// - Own-address bit 0 enables general call recognition.
// - Received address compared to own and general call; match with acknowledge enabled raises flag.
// - Flag set after a sent START, each byte the unit transfers, and a START/STOP seen while addressed; not after a sent STOP. Status then describes bus state.
// - Interrupt request needs flag, local enable and global enable.
// - Writing one clears the flag; operation starts only after clearing.
// - Sent START sets flag with a START status code.
// - Sent address or data sets flag with acknowledge-aware status code.
// - No flag after a STOP condition has been sent.
// - Clock line held low while the flag stays set and the unit is master or addressed slave.
// - Status updated the cycle after the flag; otherwise no-status code.
// - Data write with flag low sets collision; with flag high clears it.
`timescale 1ns/1ns
`include "two_wire_defines.vh"

module two_wire_unit (
    input  wire        sys_clk,
    input  wire        rst_b,
    input  wire [4:0]  avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    input  wire [3:0]  avs_byteenable,
    output reg  [31:0] avs_readdata,
    output reg         avs_waitrequest,
    input  wire        global_irq_enable,
    output reg         irq_req_r,
    input  wire        scl_in,
    output reg         scl_out_r,
    output reg         scl_oe_r,
    input  wire        sda_in,
    output reg         sda_out_r,
    output reg         sda_oe_r
);

localparam [5:0] ST_IDLE  = 6'h01;
localparam [5:0] ST_START = 6'h02;
localparam [5:0] ST_BYTE  = 6'h04;
localparam [5:0] ST_WAIT  = 6'h08;
localparam [5:0] ST_STOP  = 6'h10;
localparam [5:0] ST_RSTRT = 6'h20;

// ==========================================================
// Half bit period: (rate + 1) times 4 to the power of the prescaler select
function [15:0] half_cycles;
    input [7:0] rate;
    input [1:0] ps;
    begin
        half_cycles = ({8'h00, rate} + 16'h0001) << {ps, 1'b0};
    end
endfunction

// ==========================================================
// Line synchronisers
reg  [2:0]  scl_sync_r;
reg  [2:0]  sda_sync_r;
reg         scl_s_r;
reg         sda_s_r;
reg         busy_r;

wire scl_rise  = (scl_sync_r[2:1] == 2'b11) & ~scl_s_r;
wire scl_fall  = (scl_sync_r[2:1] == 2'b00) & scl_s_r;
wire sda_rise  = (sda_sync_r[2:1] == 2'b11) & ~sda_s_r;
wire sda_fall  = (sda_sync_r[2:1] == 2'b00) & sda_s_r;
wire start_det = sda_fall & scl_s_r;
wire stop_det  = sda_rise & scl_s_r;

always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
        scl_sync_r <= 3'h7;
        sda_sync_r <= 3'h7;
        scl_s_r    <= 1'b1;
        sda_s_r    <= 1'b1;
        busy_r     <= 1'b0;
    end else begin
        scl_sync_r <= {scl_sync_r[1:0], scl_in};
        sda_sync_r <= {sda_sync_r[1:0], sda_in};
        if (scl_sync_r[2] == scl_sync_r[1]) begin
            scl_s_r <= scl_sync_r[2];
        end
        if (sda_sync_r[2] == sda_sync_r[1]) begin
            sda_s_r <= sda_sync_r[2];
        end
        if (start_det) begin
            busy_r <= 1'b1;
        end else if (stop_det) begin
            busy_r <= 1'b0;
        end
    end
end

// ==========================================================
// Avalon slave: one wait cycle, access completes when waitrequest is low
reg  [1:0]  ps_r;
reg  [7:0]  own_r;
reg  [7:0]  rate_r;
reg         ack_en_r;
reg         sta_r;
reg         en_r;
reg         ie_r;
reg  [7:0]  data_r;
reg         flag_r;
reg         wcol_r;
reg         sto_r;
reg  [4:0]  stat_r;
reg  [7:0]  rd_nxt;

wire wr      = avs_write & ~avs_waitrequest & avs_byteenable[0];
wire wr_stat = wr & (avs_address == `A_STAT);
wire wr_data = wr & (avs_address == `A_DATA);
wire wr_addr = wr & (avs_address == `A_ADDR);
wire wr_ctrl = wr & (avs_address == `A_CTRL);
wire wr_rate = wr & (avs_address == `A_RATE);
wire go      = wr_ctrl & avs_writedata[`C_FLAG] & flag_r;

always @* begin
    case (avs_address)
        `A_STAT: rd_nxt = {stat_r, 1'b0, ps_r};
        `A_DATA: rd_nxt = data_r;
        `A_ADDR: rd_nxt = own_r;
        `A_CTRL: rd_nxt = {flag_r, ack_en_r, sta_r, sto_r, wcol_r, en_r, 1'b0, ie_r};
        `A_RATE: rd_nxt = rate_r;
        default: rd_nxt = 8'h00;
    endcase
end

always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
        avs_waitrequest <= 1'b1;
        avs_readdata    <= 32'h0;
        ps_r            <= 2'h0;
        own_r           <= 8'h00;
        rate_r          <= 8'h00;
        ack_en_r        <= 1'b0;
        sta_r           <= 1'b0;
        en_r            <= 1'b0;
        ie_r            <= 1'b0;
        irq_req_r       <= 1'b0;
    end else begin
        if (avs_waitrequest & (avs_read | avs_write)) begin
            avs_waitrequest <= 1'b0;
            avs_readdata    <= {24'h0, rd_nxt};
        end else begin
            avs_waitrequest <= 1'b1;
        end
        if (wr_stat) begin
            ps_r <= avs_writedata[1:0];
        end
        if (wr_addr) begin
            own_r <= avs_writedata[7:0];
        end
        if (wr_rate) begin
            rate_r <= avs_writedata[7:0];
        end
        if (wr_ctrl) begin
            ack_en_r <= avs_writedata[`C_ACKEN];
            sta_r    <= avs_writedata[`C_STA];
            en_r     <= avs_writedata[`C_EN];
            ie_r     <= avs_writedata[`C_IE];
        end
        irq_req_r <= flag_r & ie_r & global_irq_enable;
    end
end

// ==========================================================
// Byte engine
reg  [5:0]  st_r;
reg  [4:0]  code_r;
reg  [15:0] tmr_r;
reg  [3:0]  cnt_r;
reg         master_r;
reg         slv_r;
reg         xmit_r;
reg         addr_ph_r;
reg         mrx_r;
reg         stx_r;
reg         ack_r;
reg         lost_r;

wire [15:0] half_w = half_cycles(rate_r, ps_r);
wire        tmr_run = scl_oe_r | scl_s_r;
wire        tdone  = (tmr_r == `HALF_ZERO) & tmr_run;
wire        gc_hit = (data_r[7:1] == `GC_ADDR) & own_r[0];
wire        match  = (data_r[7:1] == own_r[7:1]) | gc_hit;
wire        xmit_n = master_r ? (addr_ph_r | ~mrx_r) : stx_r;

always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
        st_r      <= ST_IDLE;
        code_r    <= `CODE_NONE;
        stat_r    <= `CODE_NONE;
        tmr_r     <= `HALF_ZERO;
        cnt_r     <= 4'h0;
        data_r    <= `DATA_RST;
        flag_r    <= 1'b0;
        wcol_r    <= 1'b0;
        sto_r     <= 1'b0;
        master_r  <= 1'b0;
        slv_r     <= 1'b0;
        xmit_r    <= 1'b0;
        addr_ph_r <= 1'b0;
        mrx_r     <= 1'b0;
        stx_r     <= 1'b0;
        ack_r     <= 1'b0;
        lost_r    <= 1'b0;
        scl_oe_r  <= 1'b0;
        sda_oe_r  <= 1'b0;
        scl_out_r <= 1'b0;
        sda_out_r <= 1'b0;
    end else begin
        scl_out_r <= 1'b0;
        sda_out_r <= 1'b0;
        stat_r <= flag_r ? code_r : `CODE_NONE;
        if (wr_data) begin
            if (flag_r) begin
                data_r <= avs_writedata[7:0];
                wcol_r <= 1'b0;
            end else begin
                wcol_r <= 1'b1;
            end
        end
        if (wr_ctrl) begin
            sto_r <= avs_writedata[`C_STO];
            if (avs_writedata[`C_FLAG]) begin
                flag_r <= 1'b0;
            end
        end
        if ((tmr_r != `HALF_ZERO) & tmr_run) begin
            tmr_r <= tmr_r - 16'h0001;
        end
        if (!en_r) begin
            st_r     <= ST_IDLE;
            master_r <= 1'b0;
            slv_r    <= 1'b0;
            scl_oe_r <= 1'b0;
            sda_oe_r <= 1'b0;
        end else begin
            case (st_r)
                ST_IDLE: begin
                    scl_oe_r <= 1'b0;
                    sda_oe_r <= 1'b0;
                    if (sta_r & ~busy_r & ~flag_r) begin
                        st_r     <= ST_START;
                        master_r <= 1'b1;
                        sda_oe_r <= 1'b1;
                        code_r   <= `CODE_START;
                        tmr_r    <= half_w;
                    end else if (start_det) begin
                        st_r      <= ST_BYTE;
                        master_r  <= 1'b0;
                        slv_r     <= 1'b0;
                        xmit_r    <= 1'b0;
                        addr_ph_r <= 1'b1;
                        cnt_r     <= `CNT_SYNC;
                    end
                end
                ST_START: begin
                    if (tdone & ~scl_oe_r) begin
                        scl_oe_r <= 1'b1;
                        tmr_r    <= half_w;
                    end else if (tdone) begin
                        flag_r    <= 1'b1;
                        addr_ph_r <= 1'b1;
                        st_r      <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    scl_oe_r <= master_r | slv_r;
                    // The go write's own start and stop bits pick the next step
                    if (go & master_r & avs_writedata[`C_STO]) begin
                        st_r     <= ST_STOP;
                        sda_oe_r <= 1'b1;
                        tmr_r    <= half_w;
                    end else if (go & master_r & avs_writedata[`C_STA]) begin
                        st_r     <= ST_RSTRT;
                        sda_oe_r <= 1'b0;
                        tmr_r    <= half_w;
                    end else if (go & ~master_r & (avs_writedata[`C_STO] | ~slv_r)) begin
                        st_r     <= ST_IDLE;
                        slv_r    <= 1'b0;
                        sto_r    <= 1'b0;
                        scl_oe_r <= 1'b0;
                    end else if (go) begin
                        st_r     <= ST_BYTE;
                        cnt_r    <= 4'h0;
                        xmit_r   <= xmit_n;
                        sda_oe_r <= xmit_n & ~data_r[7];
                        scl_oe_r <= master_r;
                        tmr_r    <= half_w;
                    end
                end
                ST_BYTE: begin
                    if (master_r & tdone) begin
                        scl_oe_r <= ~scl_oe_r;
                        tmr_r    <= half_w;
                    end
                    if (~master_r & (start_det | stop_det) & slv_r) begin
                        flag_r   <= 1'b1;
                        code_r   <= `CODE_SR_STOP;
                        slv_r    <= 1'b0;
                        sda_oe_r <= 1'b0;
                        st_r     <= ST_WAIT;
                    end else if (~master_r & start_det) begin
                        addr_ph_r <= 1'b1;
                        cnt_r     <= `CNT_SYNC;
                        sda_oe_r  <= 1'b0;
                    end else if (~master_r & stop_det) begin
                        st_r     <= ST_IDLE;
                        sda_oe_r <= 1'b0;
                    end else if (scl_rise) begin
                        if (cnt_r == `CNT_ACK) begin
                            ack_r <= ~sda_s_r;
                        end else begin
                            data_r <= {data_r[6:0], sda_s_r};
                            if (master_r & xmit_r & ~sda_oe_r & ~sda_s_r) begin
                                master_r <= 1'b0;
                                lost_r   <= 1'b1;
                                xmit_r   <= 1'b0;
                            end
                        end
                    end else if (scl_fall & (cnt_r == `CNT_ACK)) begin
                        sda_oe_r  <= 1'b0;
                        flag_r    <= 1'b1;
                        st_r      <= ST_WAIT;
                        addr_ph_r <= 1'b0;
                        lost_r    <= 1'b0;
                        if (lost_r) begin
                            code_r <= `CODE_ARB_LOST;
                        end else if (master_r & addr_ph_r) begin
                            mrx_r  <= data_r[0];
                            code_r <= data_r[0] ?
                                      (ack_r ? `CODE_MR_SLA_A : `CODE_MR_SLA_N) :
                                      (ack_r ? `CODE_MT_SLA_A : `CODE_MT_SLA_N);
                        end else if (master_r & mrx_r) begin
                            code_r <= ack_r ? `CODE_MR_DAT_A : `CODE_MR_DAT_N;
                        end else if (master_r) begin
                            code_r <= ack_r ? `CODE_MT_DAT_A : `CODE_MT_DAT_N;
                        end else if (addr_ph_r) begin
                            slv_r  <= 1'b1;
                            stx_r  <= data_r[0];
                            code_r <= data_r[0] ? `CODE_ST_SLA :
                                      (gc_hit ? `CODE_SR_GC : `CODE_SR_SLA);
                        end else if (stx_r) begin
                            code_r <= ack_r ? `CODE_ST_DAT_A : `CODE_ST_DAT_N;
                        end else begin
                            code_r <= `CODE_SR_DAT;
                        end
                    end else if (scl_fall) begin
                        cnt_r <= cnt_r + 4'h1;
                        if (cnt_r == `CNT_LAST) begin
                            if (xmit_r) begin
                                sda_oe_r <= 1'b0;
                            end else if (addr_ph_r & ~master_r) begin
                                sda_oe_r <= match & ack_en_r;
                                if (~(match & ack_en_r)) begin
                                    st_r <= ST_IDLE;
                                end
                            end else begin
                                sda_oe_r <= ack_en_r;
                            end
                        end else begin
                            sda_oe_r <= xmit_r & ~data_r[7];
                        end
                    end
                end
                ST_STOP: begin
                    if (tdone & scl_oe_r) begin
                        scl_oe_r <= 1'b0;
                        tmr_r    <= half_w;
                    end else if (tdone) begin
                        sda_oe_r <= 1'b0;
                        master_r <= 1'b0;
                        sto_r    <= 1'b0;
                        st_r     <= ST_IDLE;
                    end
                end
                ST_RSTRT: begin
                    if (tdone & scl_oe_r) begin
                        scl_oe_r <= 1'b0;
                        tmr_r    <= half_w;
                    end else if (tdone) begin
                        sda_oe_r <= 1'b1;
                        code_r   <= `CODE_RSTART;
                        tmr_r    <= half_w;
                        st_r     <= ST_START;
                    end
                end
                default: begin
                    st_r <= ST_IDLE;
                end
            endcase
        end
    end
end

// Data register keeps its content across sleep; no value is promised then
// Shift only runs in ST_BYTE, which is never entered while the flag is set

endmodule

// ### tb/i2c_slave_model.sv
// Behavioural slave on the two-wire bus that acknowledges its own address
`timescale 1ns/1ns
module i2c_slave_model #(
    parameter [6:0] SLV_ADDR = 7'h2a
) (
    input  wire       scl,
    input  wire       sda,
    input  wire       ack_en,
    input  wire       stretch,
    output reg        scl_oe,
    output reg        sda_oe,
    output reg  [7:0] rx_byte,
    output reg        rx_stb
);
    reg [3:0] bitn;
    reg [7:0] sh;
    reg       first;
    reg       sel;
    initial begin
        {scl_oe, sda_oe, rx_stb, first, sel} = 5'h00;
        bitn = 4'h0;
        sh = 8'h00;
        rx_byte = 8'h00;
    end
    // ==========
    // Start condition marks the address byte
    always @(negedge sda) begin
        if (scl === 1'b1) begin
            bitn = 4'h0;
            first = 1'b1;
        end
    end
    always @(posedge scl) begin
        if (bitn < 4'h8)
            sh = {sh[6:0], sda};
        bitn = bitn + 4'h1;
    end
    // ==========
    // Acknowledge, release and optional clock stretch
    always @(negedge scl) begin
        if (bitn == 4'h8) begin
            if (first)
                sel = (sh[7:1] == SLV_ADDR) && !sh[0];
            sda_oe = sel && ack_en;
            rx_byte = sh;
            rx_stb = 1'b1;
        end else if (bitn == 4'h9) begin
            sda_oe = 1'b0;
            rx_stb = 1'b0;
            first = 1'b0;
            bitn = 4'h0;
        end else if (bitn == 4'h4 && stretch) begin
            scl_oe = 1'b1;
            #400 scl_oe = 1'b0;
        end
    end
endmodule

// ### tb/test_two_wire_status_data_addr.sv
// Self-checking bench of the two-wire unit: registers and master writes
`timescale 1ns/1ns
`include "two_wire_defines.vh"
module test_two_wire_status_data_addr;
    reg         sys_clk = 1'b0;
    reg         rst_b = 1'b0;
    reg  [4:0]  avs_address = 5'h00;
    reg         avs_read = 1'b0;
    reg         avs_write = 1'b0;
    reg  [31:0] avs_writedata = 32'h0;
    reg         global_irq_enable = 1'b1;
    reg         ack_en = 1'b1;
    reg         stretch = 1'b0;
    wire [31:0] avs_readdata;
    wire        avs_waitrequest, irq_req_r, scl_out_r, scl_oe_r, sda_out_r, sda_oe_r;
    wire        s_scl_oe, s_sda_oe, rx_stb;
    wire [7:0]  rx_byte;
    wire        scl = !(scl_oe_r && !scl_out_r) && !s_scl_oe;
    wire        sda = !(sda_oe_r && !sda_out_r) && !s_sda_oe;
    reg  [15:0] exp_q[$];
    reg  [7:0]  rx_q[$];
    reg  [15:0] cur;
    reg  [31:0] seed = 32'h000083bf;
    reg  [7:0]  rd_val;
    integer     errors = 0;
    integer     num_checks = 0;
    integer     i;
    always #2 sys_clk = ~sys_clk;
    two_wire_unit dut (.sys_clk(sys_clk), .rst_b(rst_b), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'hf), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .global_irq_enable(global_irq_enable), .irq_req_r(irq_req_r), .scl_in(scl),
        .scl_out_r(scl_out_r), .scl_oe_r(scl_oe_r), .sda_in(sda), .sda_out_r(sda_out_r),
        .sda_oe_r(sda_oe_r));
    i2c_slave_model slv (.scl(scl), .sda(sda), .ack_en(ack_en), .stretch(stretch),
        .scl_oe(s_scl_oe), .sda_oe(s_sda_oe), .rx_byte(rx_byte), .rx_stb(rx_stb));
    function [31:0] xs(input [31:0] s);
        reg [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        xs = x ^ (x << 5);
    endfunction
    task chk(input string nm, input [7:0] e, input [7:0] g);
        num_checks = num_checks + 1;
        if (g !== e) begin
            errors = errors + 1;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask
    // ==========
    // Avalon access; reads note mask and expected byte
    task bus(input wr, input [4:0] a, input [7:0] d, input [7:0] m, input [7:0] e);
        integer n;
        n = 0;
        if (!wr)
            exp_q.push_back({m, e});
        avs_address <= a;
        avs_writedata <= {24'h0, d};
        avs_read <= !wr;
        avs_write <= wr;
        @(posedge sys_clk);
        while (avs_waitrequest !== 1'b0 && n < 200) begin
            n = n + 1;
            @(posedge sys_clk);
        end
        if (n == 200)
            errors = errors + 1;
        rd_val = avs_readdata[7:0];
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge sys_clk);
    endtask
    always @(posedge sys_clk) begin
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0 && exp_q.size() > 0) begin
            cur = exp_q.pop_front();
            if (cur[15:8] != 8'h00)
                chk("read data", cur[7:0], avs_readdata[7:0] & cur[15:8]);
        end
    end
    always @(posedge rx_stb) begin
        if (rx_q.size() > 0)
            chk("bus byte", rx_q.pop_front(), rx_byte);
        else
            chk("bus byte count", 8'h00, 8'h01);
    end
    task wait_flag;
        integer k;
        k = 0;
        rd_val = 8'h00;
        while (rd_val[7] !== 1'b1 && k < 400) begin
            bus(1'b1 ^ 1'b1, `A_CTRL, 8'h00, 8'h00, 8'h00);
            k = k + 1;
        end
        if (k == 400)
            errors = errors + 1;
    endtask
    task start_bus;
        bus(1'b1, `A_CTRL, 8'ha5, 0, 0);
        wait_flag;
        bus(1'b0, `A_STAT, 0, 8'hf8, {`CODE_START, 3'h0});
    endtask
    task send(input [7:0] b, input ack, input [4:0] code);
        ack_en <= ack;
        bus(1'b1, `A_DATA, b, 0, 0);
        rx_q.push_back(b);
        bus(1'b0, `A_DATA, 0, 8'hff, b);
        bus(1'b1, `A_CTRL, 8'h85, 0, 0);
        wait_flag;
        bus(1'b0, `A_STAT, 0, 8'hf8, {code, 3'h0});
        bus(1'b0, `A_DATA, 0, 8'hff, b);
    endtask
    task stop_bus;
        bus(1'b1, `A_CTRL, 8'h95, 0, 0);
        repeat (300) @(posedge sys_clk);
        bus(1'b0, `A_CTRL, 0, 8'h80, 8'h00);
        bus(1'b0, `A_STAT, 0, 8'hff, 8'hf8);
    endtask
    task final_report;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        #300000;
        errors = errors + 1;
        final_report;
    end
    initial begin
        repeat (16) @(posedge sys_clk);
        rst_b <= 1'b1;
        @(posedge sys_clk);
        bus(1'b0, `A_STAT, 0, 8'hff, 8'hf8);
        bus(1'b0, `A_DATA, 0, 8'hff, `DATA_RST);
        bus(1'b0, `A_ADDR, 0, 8'hff, 8'h00);
        bus(1'b1, 5'h14, 8'h5a, 0, 0);
        bus(1'b0, 5'h14, 0, 8'hff, 8'h00);
        $display("test reset values done");
        for (i = 0; i < 4; i = i + 1) begin
            seed = xs(seed);
            bus(1'b1, `A_STAT, {seed[7:2], i[1:0]}, 0, 0);
            bus(1'b0, `A_STAT, 0, 8'hff, {`CODE_NONE, 1'b0, i[1:0]});
        end
        bus(1'b1, `A_STAT, 8'h00, 0, 0);
        seed = xs(seed);
        bus(1'b1, `A_ADDR, seed[7:0], 0, 0);
        bus(1'b0, `A_ADDR, 0, 8'hff, seed[7:0]);
        bus(1'b1, `A_DATA, 8'h3c, 0, 0);
        bus(1'b0, `A_DATA, 0, 8'hff, `DATA_RST);
        bus(1'b0, `A_CTRL, 0, 8'h08, 8'h08);
        $display("test registers done");
        bus(1'b1, `A_RATE, 8'h13, 0, 0);
        start_bus;
        repeat (2) @(posedge sys_clk);
        chk("irq", 8'h01, {7'h0, irq_req_r});
        global_irq_enable <= 1'b0;
        repeat (2) @(posedge sys_clk);
        chk("irq", 8'h00, {7'h0, irq_req_r});
        global_irq_enable <= 1'b1;
        send({7'h2a, 1'b0}, 1'b1, `CODE_MT_SLA_A);
        bus(1'b0, `A_CTRL, 0, 8'h08, 8'h00);
        stretch <= 1'b1;
        seed = xs(seed);
        send(seed[7:0], 1'b1, `CODE_MT_DAT_A);
        stretch <= 1'b0;
        seed = xs(seed);
        send(seed[7:0], 1'b0, `CODE_MT_DAT_N);
        stop_bus;
        $display("test master write done");
        start_bus;
        send({7'h55, 1'b0}, 1'b1, `CODE_MT_SLA_N);
        stop_bus;
        chk("bytes left", 8'h00, 8'(rx_q.size()));
        $display("test address nack done");
        final_report;
    end
endmodule
bind two_wire_unit two_wire_props props_i (.sys_clk(sys_clk), .rst_b(rst_b),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .global_irq_enable(global_irq_enable), .irq_req_r(irq_req_r), .scl_in(scl_in),
    .scl_out_r(scl_out_r), .scl_oe_r(scl_oe_r), .sda_in(sda_in), .sda_out_r(sda_out_r),
    .sda_oe_r(sda_oe_r));

// ### tb/two_wire_props.sv
// Port-level checker of the two-wire unit
`timescale 1ns/1ns
`include "two_wire_defines.vh"
module two_wire_props (
    input wire        sys_clk,
    input wire        rst_b,
    input wire [4:0]  avs_address,
    input wire        avs_read,
    input wire        avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0]  avs_byteenable,
    input wire [31:0] avs_readdata,
    input wire        avs_waitrequest,
    input wire        global_irq_enable,
    input wire        irq_req_r,
    input wire        scl_in,
    input wire        scl_out_r,
    input wire        scl_oe_r,
    input wire        sda_in,
    input wire        sda_out_r,
    input wire        sda_oe_r
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    reg  [1:0] ps_r;
    wire       done    = !avs_waitrequest;
    wire       stat_rd = avs_read && done && avs_address == `A_STAT;
    wire       go_wr   = avs_write && done && avs_address == `A_CTRL && avs_writedata[7];
    // ==========
    // Shadow of the prescaler select
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b)
            ps_r <= 2'h0;
        else if (avs_write && done && avs_address == `A_STAT && avs_byteenable[0])
            ps_r <= avs_writedata[1:0];
    end
    // ==========
    // Properties
    property p_wait_ack; (avs_read || avs_write) && avs_waitrequest |=> done; endproperty
    property p_wait_one; done |=> avs_waitrequest; endproperty
    property p_stat_rsvd; stat_rd |-> avs_readdata[2] == 1'b0; endproperty
    property p_stat_ps; stat_rd |-> avs_readdata[1:0] == ps_r; endproperty
    property p_rd_hi; done |-> avs_readdata[31:8] == 24'h0; endproperty
    property p_irq_gie; irq_req_r |-> $past(global_irq_enable); endproperty
    property p_hold_scl; irq_req_r && $past(irq_req_r) |-> $past(scl_oe_r); endproperty
    property p_start_flag; $rose(sda_oe_r) && !scl_oe_r |-> ##[1:120] irq_req_r; endproperty
    property p_go; go_wr && irq_req_r |-> ##[1:60] $fell(scl_oe_r); endproperty
    property p_stop_quiet; $fell(sda_oe_r) && !scl_oe_r |=> !irq_req_r [*8]; endproperty
    a_wait_ack: assert property (p_wait_ack) else $error("no answer");
    a_wait_one: assert property (p_wait_one) else $error("long answer");
    a_stat_rsvd: assert property (p_stat_rsvd) else $error("bit 2 set");
    a_stat_ps: assert property (p_stat_ps) else $error("prescale bits");
    a_rd_hi: assert property (p_rd_hi) else $error("upper bits");
    a_irq_gie: assert property (p_irq_gie) else $error("irq ungated");
    a_hold_scl: assert property (p_hold_scl) else $error("scl free");
    a_start_flag: assert property (p_start_flag) else $error("no start flag");
    a_go: assert property (p_go) else $error("no resume");
    a_stop_quiet: assert property (p_stop_quiet) else $error("flag on stop");
    c_flag: cover property ($rose(irq_req_r));
    c_stat: cover property (stat_rd);
    c_start: cover property ($rose(sda_oe_r) && !scl_oe_r);
endmodule
